// >>> rtl/oad_decoder.sv
// operand addressing decoder: prefixes, flag ops, mod/rm addressing
// assumes the prefetch queue presents one byte per cycle with byte_valid,
// register values are held stable by the execution unit during a decode
`timescale 1ns/10ps
`include "oad_defines.svh"

module oad_decoder #(
    parameter int XFER_W = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    input wire logic has_modrm,
    input wire logic word_op,
    input wire logic string_dest,
    input wire logic [XFER_W-1:0] mem_xfers,
    input wire logic [15:0] base_register,
    input wire logic [15:0] frame_pointer,
    input wire logic [15:0] source_index,
    input wire logic [15:0] destination_index,
    output logic carry_flag,
    output logic direction_flag,
    output logic irq_enable_flag,
    output logic bus_lock,
    output logic decode_done,
    output logic reg_operand,
    output logic [2:0] reg_sel,
    output logic reg_high_byte,
    output logic [1:0] seg_sel,
    output logic [15:0] effective_address,
    output logic [3:0] instr_len,
    output logic [5:0] clocks
);
    ////////////////////////////////////////////////////////////////////////
    // state
    oad_pkg::oad_state_e state_reg, state_next;
    logic [1:0] mod_reg;
    logic [2:0] rm_reg;
    logic [1:0] disp_left_reg;
    logic [15:0] disp_reg;
    logic ovr_valid_reg;
    logic [1:0] ovr_seg_reg;
    logic lock_pend_reg;
    logic [3:0] len_reg;
    logic [5:0] pfx_clk_reg;
    logic wop_reg;
    logic sdest_reg;
    logic [XFER_W-1:0] xfer_reg;

    ////////////////////////////////////////////////////////////////////////
    // byte classification
    wire take = byte_valid;
    wire is_lock = byte_in == `OAD_OP_LOCK;
    wire is_seg_pfx = (byte_in & `OAD_SEG_PFX_MASK) == `OAD_SEG_PFX_VAL;
    wire is_flag_op = (byte_in == `OAD_OP_CMC) ||
                      (byte_in[7:3] == 5'h1f && byte_in[2:1] != 2'h3);
    wire [1:0] mb_mod = byte_in[7:6];
    wire [2:0] mb_rm = byte_in[2:0];
    wire mb_direct = mb_mod == `OAD_MOD_NODISP && mb_rm == `OAD_RM_DIRECT;

    // displacement byte count of a mod/rm byte; called once below, as mb_disp
    function automatic logic [1:0] disp_count(input logic [1:0] m,
                                              input logic [2:0] r);
        if (m == `OAD_MOD_DISP8)
            disp_count = 2'h1;
        else if (m == `OAD_MOD_DISP16)
            disp_count = 2'h2;
        else if (m == `OAD_MOD_NODISP && r == `OAD_RM_DIRECT)
            disp_count = 2'h2;
        else
            disp_count = 2'h0;
    endfunction

    wire [1:0] mb_disp = disp_count(mb_mod, mb_rm);

    ////////////////////////////////////////////////////////////////////////
    // effective address formation from latched fields
    wire reg_mode = mod_reg == `OAD_MOD_REG;
    wire direct = mod_reg == `OAD_MOD_NODISP && rm_reg == `OAD_RM_DIRECT;
    wire [15:0] base_a = rm_reg[2] ? 16'h0000 :
                         (rm_reg[1] ? frame_pointer : base_register);
    wire [15:0] idx_a = rm_reg[2] ?
        (rm_reg[1] ? (rm_reg[0] ? base_register : frame_pointer)
                   : (rm_reg[0] ? destination_index : source_index)) :
        (rm_reg[0] ? destination_index : source_index);
    wire [15:0] ea_sum = direct ? disp_reg :
                         16'(base_a + idx_a + disp_reg);
    // frame pointer reached by rm 010, 011, 110 outside direct mode
    wire uses_fp = !direct && (rm_reg[2:1] == 2'h1 || rm_reg == 3'h6);
    wire [1:0] seg_dflt = uses_fp ? `OAD_SEG_SS : `OAD_SEG_DS;
    // string destination wins over any override: it is not overridable
    wire [1:0] seg_fin = sdest_reg ? `OAD_SEG_ES :
                         (ovr_valid_reg ? ovr_seg_reg : seg_dflt);
    wire [5:0] word_cost = wop_reg ?
        6'(xfer_reg * `OAD_WORD_XFER_CLOCKS) : 6'h00;
    wire [5:0] ea_cost = reg_mode ? 6'h00 : `OAD_EA_CLOCKS;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            oad_pkg::OAD_OPCODE:
                if (take && !is_lock && !is_seg_pfx && !is_flag_op)
                    state_next = has_modrm ? oad_pkg::OAD_MODRM
                                           : oad_pkg::OAD_DONE;
            oad_pkg::OAD_MODRM:
                if (take)
                    state_next = (mb_disp != 2'h0) ? oad_pkg::OAD_DISP
                                                   : oad_pkg::OAD_DONE;
            oad_pkg::OAD_DISP:
                if (take && disp_left_reg == 2'h1)
                    state_next = oad_pkg::OAD_DONE;
            oad_pkg::OAD_DONE:
                state_next = oad_pkg::OAD_OPCODE;
            default:
                state_next = oad_pkg::OAD_OPCODE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // flag ops: each touches only its own flag
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            carry_flag <= 1'b0;
            direction_flag <= 1'b0;
            irq_enable_flag <= 1'b0;
        end
        else if (take && state_reg == oad_pkg::OAD_OPCODE)
        begin
            if (byte_in == `OAD_OP_CMC)
                carry_flag <= ~carry_flag;
            if (byte_in == `OAD_OP_CLC || byte_in == `OAD_OP_STC)
                carry_flag <= byte_in[0];
            if (byte_in == `OAD_OP_CLI || byte_in == `OAD_OP_STI)
                irq_enable_flag <= byte_in[0];
            if (byte_in == `OAD_OP_CLD || byte_in == `OAD_OP_STD)
                direction_flag <= byte_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prefix, opcode and mod/rm capture
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= oad_pkg::OAD_OPCODE;
            mod_reg <= 2'h0;
            rm_reg <= 3'h0;
            disp_left_reg <= 2'h0;
            disp_reg <= 16'h0000;
            ovr_valid_reg <= 1'b0;
            ovr_seg_reg <= 2'h0;
            lock_pend_reg <= 1'b0;
            len_reg <= 4'h0;
            pfx_clk_reg <= 6'h00;
            wop_reg <= 1'b0;
            sdest_reg <= 1'b0;
            xfer_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == oad_pkg::OAD_DONE)
            begin
                ovr_valid_reg <= 1'b0;
                lock_pend_reg <= 1'b0;
                len_reg <= 4'h0;
                pfx_clk_reg <= 6'h00;
            end
            else if (take)
                len_reg <= 4'(len_reg + 4'h1);
            if (take && state_reg == oad_pkg::OAD_OPCODE)
            begin
                if (is_lock)
                begin
                    lock_pend_reg <= 1'b1;
                    pfx_clk_reg <= 6'(pfx_clk_reg + `OAD_FLAG_OP_CLOCKS);
                end
                if (is_seg_pfx)
                begin
                    ovr_valid_reg <= 1'b1;
                    ovr_seg_reg <= byte_in[4:3];
                end
                // a flag op never passes the done state, so its prefixes
                // are dropped here or they would stick to the next one
                if (is_flag_op)
                begin
                    len_reg <= 4'h0; // single byte, reported via flag_done
                    lock_pend_reg <= 1'b0;
                    ovr_valid_reg <= 1'b0;
                    pfx_clk_reg <= 6'h00;
                end
                wop_reg <= word_op;
                sdest_reg <= string_dest;
                xfer_reg <= mem_xfers;
                mod_reg <= `OAD_MOD_REG;
                disp_reg <= 16'h0000;
            end
            if (take && state_reg == oad_pkg::OAD_MODRM)
            begin
                mod_reg <= mb_mod;
                rm_reg <= mb_rm;
                disp_left_reg <= mb_disp;
                disp_reg <= 16'h0000;
            end
            if (take && state_reg == oad_pkg::OAD_DISP)
            begin
                disp_left_reg <= 2'(disp_left_reg - 2'h1);
                if (mod_reg == `OAD_MOD_DISP8)
                    disp_reg <= {{8{byte_in[7]}}, byte_in};
                else if (disp_left_reg == 2'h2)
                    disp_reg[7:0] <= byte_in;
                else
                    disp_reg[15:8] <= byte_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // results to execution logic, all registered
    wire flag_done = take && state_reg == oad_pkg::OAD_OPCODE && is_flag_op;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bus_lock <= 1'b0;
            decode_done <= 1'b0;
            reg_operand <= 1'b0;
            reg_sel <= 3'h0;
            reg_high_byte <= 1'b0;
            seg_sel <= `OAD_SEG_DS;
            effective_address <= 16'h0000;
            instr_len <= 4'h0;
            clocks <= 6'h00;
        end
        else
        begin
            decode_done <= 1'b0;
            if (flag_done)
            begin
                decode_done <= 1'b1;
                instr_len <= 4'(len_reg + 4'h1);
                clocks <= 6'(pfx_clk_reg + `OAD_FLAG_OP_CLOCKS);
                bus_lock <= lock_pend_reg;
            end
            else if (state_reg == oad_pkg::OAD_DONE)
            begin
                decode_done <= 1'b1;
                bus_lock <= lock_pend_reg;
                reg_operand <= reg_mode;
                reg_sel <= rm_reg;
                reg_high_byte <= reg_mode && !wop_reg && rm_reg[2];
                seg_sel <= seg_fin;
                effective_address <= reg_mode ? 16'h0000 : ea_sum;
                instr_len <= len_reg;
                clocks <= 6'(pfx_clk_reg + ea_cost + word_cost);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    lock_cost_a: assert property (@(posedge mclk) disable iff (rst)
        take && state_reg == oad_pkg::OAD_OPCODE && byte_in == `OAD_OP_LOCK
        |=> pfx_clk_reg == $past(pfx_clk_reg) + 6'h02)
        else $error("lock prefix cost wrong");
    lock_scope_a: assert property (@(posedge mclk) disable iff (rst)
        flag_done |=> !lock_pend_reg && !ovr_valid_reg)
        else $error("prefix outlived its instruction");
    carry_invert_a: assert property (@(posedge mclk) disable iff (rst)
        take && state_reg == oad_pkg::OAD_OPCODE && byte_in == `OAD_OP_CMC
        |=> carry_flag != $past(carry_flag) && decode_done)
        else $error("carry not inverted");
    flag_only_a: assert property (@(posedge mclk) disable iff (rst)
        take && state_reg == oad_pkg::OAD_OPCODE && byte_in == `OAD_OP_STD
        |=> direction_flag && $stable(carry_flag) && $stable(irq_enable_flag))
        else $error("flag op touched other flag");
    disp8_sign_a: assert property (@(posedge mclk) disable iff (rst)
        take && state_reg == oad_pkg::OAD_DISP
        && mod_reg == `OAD_MOD_DISP8
        |=> disp_reg[15:8] == {8{$past(byte_in[7])}})
        else $error("disp8 not sign extended");
    reg_mode_a: assert property (@(posedge mclk) disable iff (rst)
        state_reg == oad_pkg::OAD_DONE && reg_mode
        |=> reg_operand && effective_address == 16'h0000)
        else $error("register mode formed address");
    direct_len_a: assert property (@(posedge mclk) disable iff (rst)
        take && state_reg == oad_pkg::OAD_MODRM && mb_direct
        |=> state_reg == oad_pkg::OAD_DISP && disp_left_reg == 2'h2)
        else $error("direct mode not two bytes");
    ea_cost_a: assert property (@(posedge mclk) disable iff (rst)
        state_reg == oad_pkg::OAD_DONE && !reg_mode && !wop_reg
        |=> clocks == $past(pfx_clk_reg) + 6'h04)
        else $error("ea cost not 4");
    string_es_a: assert property (@(posedge mclk) disable iff (rst)
        state_reg == oad_pkg::OAD_DONE && sdest_reg
        |=> seg_sel == `OAD_SEG_ES)
        else $error("string dest not es");
    fp_stack_a: assert property (@(posedge mclk) disable iff (rst)
        state_reg == oad_pkg::OAD_DONE && uses_fp && !sdest_reg
        && !ovr_valid_reg |=> seg_sel == `OAD_SEG_SS)
        else $error("frame pointer not stack seg");
    cov_override_c: cover property (@(posedge mclk)
        decode_done && seg_sel == `OAD_SEG_CS);
    cov_lock_c: cover property (@(posedge mclk) decode_done && bus_lock);
    cov_disp16_c: cover property (@(posedge mclk)
        decode_done && instr_len == 4'h4);
endmodule

// >>> rtl/oad_defines.svh
// constants for the operand addressing decoder: opcodes, field codes, costs
// assumes a 125 MHz core clock; counts are in core clocks
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
`define OAD_OP_LOCK 8'hf0
`define OAD_OP_CMC 8'hf5
`define OAD_OP_CLC 8'hf8
`define OAD_OP_STC 8'hf9
`define OAD_OP_CLI 8'hfa
`define OAD_OP_STI 8'hfb
`define OAD_OP_CLD 8'hfc
`define OAD_OP_STD 8'hfd
`define OAD_SEG_PFX_MASK 8'he7
`define OAD_SEG_PFX_VAL 8'h26
`define OAD_MOD_NODISP 2'h0
`define OAD_MOD_DISP8 2'h1
`define OAD_MOD_DISP16 2'h2
`define OAD_MOD_REG 2'h3
`define OAD_RM_DIRECT 3'h6
`define OAD_SEG_ES 2'h0
`define OAD_SEG_CS 2'h1
`define OAD_SEG_SS 2'h2
`define OAD_SEG_DS 2'h3
`define OAD_FLAG_OP_CLOCKS 6'h02
`define OAD_EA_CLOCKS 6'h04
`define OAD_WORD_XFER_CLOCKS 6'h04
`endif

// >>> rtl/oad_pkg.sv
// types for the operand addressing decoder
// used by oad_decoder only
package oad_pkg;
    typedef enum logic [3:0] {
        OAD_OPCODE = 4'b0001,
        OAD_MODRM = 4'b0010,
        OAD_DISP = 4'b0100,
        OAD_DONE = 4'b1000
    } oad_state_e;
endpackage

// >>> tb/oad_fetch_model.sv
// prefetch queue stand-in: hands instruction bytes to the decoder
// assumes the bench calls put_byte at a falling edge of mclk
`timescale 1ns/10ps
module oad_fetch_model (
    input wire logic mclk,
    output logic byte_valid,
    output logic [7:0] byte_in
);
    logic [7:0] last_b;
    // idle at time zero
    initial
    begin
        byte_valid = 1'b0;
        byte_in = 8'h00;
        last_b = 8'hff;
    end
    // an idle bus shows the inverse of the last byte, not a stale copy
    task automatic release_bus();
        byte_valid = 1'b0;
        byte_in = ~last_b;
    endtask
    // gap idle cycles model a slow queue; stream order is kept
    // back-to-back bytes keep byte_valid high, so it never toggles twice
    // in one time step; the bench releases the bus after the last byte
    task automatic put_byte(input logic [7:0] b, input int gap);
        if (gap > 0)
            release_bus();
        repeat (gap) @(negedge mclk);
        byte_valid = 1'b1;
        byte_in = b;
        last_b = b;
        @(negedge mclk);
    endtask
endmodule

// >>> tb/tb_oad_decoder.sv
// self-checking bench for oad_decoder: flag ops and mod/rm addressing
// assumes oad_fetch_model feeds bytes; expectations queue to a monitor
`timescale 1ns/10ps
`include "oad_defines.svh"
module tb_oad_decoder;
    typedef struct packed {
        logic [15:0] ea;
        logic [3:0] len;
        logic [5:0] clk;
        logic [1:0] seg;
        logic [2:0] rsel;
        logic fl, mem, hi, lk, cf, df, ief;
    } oad_exp_s;
    logic mclk, rst, has_modrm, word_op, string_dest, byte_valid;
    logic [1:0] mem_xfers, seg_sel;
    logic [7:0] byte_in;
    logic [15:0] bx_v, bp_v, si_v, di_v, effective_address;
    logic carry_flag, direction_flag, irq_enable_flag, bus_lock;
    logic decode_done, reg_operand, reg_high_byte;
    logic [2:0] reg_sel;
    logic [3:0] instr_len;
    logic [5:0] clocks;
    logic cf_e, df_e, ie_e;
    logic [31:0] rnd;
    oad_exp_s exp_q[$];
    int err_count, comparisons;
    oad_fetch_model fm (.mclk(mclk), .byte_valid(byte_valid),
        .byte_in(byte_in));
    oad_decoder #(.XFER_W(2)) uut (.mclk(mclk), .rst(rst),
        .byte_valid(byte_valid), .byte_in(byte_in), .has_modrm(has_modrm),
        .word_op(word_op), .string_dest(string_dest), .mem_xfers(mem_xfers),
        .base_register(bx_v), .frame_pointer(bp_v), .source_index(si_v),
        .destination_index(di_v), .carry_flag(carry_flag),
        .direction_flag(direction_flag), .irq_enable_flag(irq_enable_flag),
        .bus_lock(bus_lock), .decode_done(decode_done),
        .reg_operand(reg_operand), .reg_sel(reg_sel),
        .reg_high_byte(reg_high_byte), .seg_sel(seg_sel),
        .effective_address(effective_address), .instr_len(instr_len),
        .clocks(clocks));
    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // compare tasks, one per kind of result
    task automatic chk_val(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, g);
        chk_val(n, {15'h0, e}, {15'h0, g});
    endtask
    task automatic complete_run();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // shifted several times per draw so successive values differ well
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        repeat (16) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction
    task automatic rnd_step();
        rnd = lfsr_next(rnd);
    endtask
    task automatic send(input logic [7:0] b);
        rnd_step();
        fm.put_byte(b, int'(rnd[1:0]));
    endtask
    // bounded wait for decode_done, which comes after the done state or, for a flag op, right after its opcode byte, then two idle cycles before the next instruction
    task automatic finish_instr();
        int n;
        fm.release_bus();
        n = 0;
        while (decode_done !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20)
            chk_bit("decode_done", 1'b1, 1'b0);
        repeat (2) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // flag instruction, optionally lock-prefixed
    task automatic flag_instr(input logic lk, input logic [7:0] op);
        oad_exp_s e;
        case (op)
            `OAD_OP_CMC: cf_e = ~cf_e;
            `OAD_OP_CLC: cf_e = 1'b0;
            `OAD_OP_STC: cf_e = 1'b1;
            `OAD_OP_CLI: ie_e = 1'b0;
            `OAD_OP_STI: ie_e = 1'b1;
            `OAD_OP_CLD: df_e = 1'b0;
            default: df_e = 1'b1;
        endcase
        e = '0;
        e.fl = 1'b1;
        e.lk = lk;
        e.len = 4'(1 + lk);
        e.clk = 6'(2 + 2 * lk);
        {e.cf, e.df, e.ief} = {cf_e, df_e, ie_e};
        has_modrm = 1'b0;
        exp_q.push_back(e);
        if (lk)
            send(`OAD_OP_LOCK);
        send(op);
        finish_instr();
    endtask
    // opcode with no mod/rm byte: only prefix cost and length report
    task automatic plain_instr(input logic lk);
        oad_exp_s e;
        e = '0;
        e.fl = 1'b1;
        e.lk = lk;
        e.len = 4'(1 + lk);
        e.clk = 6'(2 * lk);
        {e.cf, e.df, e.ief} = {cf_e, df_e, ie_e};
        {has_modrm, word_op} = 2'b00;
        exp_q.push_back(e);
        if (lk)
            send(`OAD_OP_LOCK);
        send(8'hf4);
        finish_instr();
    endtask
    // mod/rm instruction; ov[2] enables a segment override ov[1:0]
    task automatic mem_instr(input logic lk, input logic [2:0] ov,
        input logic [1:0] md, input logic [2:0] rm, input logic w, sd,
        input logic [1:0] xf);
        oad_exp_s e;
        logic [15:0] d, b;
        int nd;
        rnd_step();
        {bx_v, bp_v} = rnd;
        rnd_step();
        {si_v, di_v} = rnd;
        rnd_step();
        d = rnd[15:0];
        nd = (md == 2'h2 || (md == 2'h0 && rm == 3'h6)) ? 2 : int'(md == 2'h1);
        if (md == 2'h1)
            d = {{8{d[7]}}, d[7:0]};
        if (nd == 0)
            d = 16'h0000;
        case (rm)
            3'h0: b = bx_v + si_v;
            3'h1: b = bx_v + di_v;
            3'h2: b = bp_v + si_v;
            3'h3: b = bp_v + di_v;
            3'h4: b = si_v;
            3'h5: b = di_v;
            3'h6: b = bp_v;
            default: b = bx_v;
        endcase
        e = '0;
        e.ea = (md == 2'h0 && rm == 3'h6) ? d : b + d;
        e.seg = sd ? 2'h0 : ov[2] ? ov[1:0] :
            (rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0)) ?
            2'h2 : 2'h3;
        e.len = 4'(2 + nd + lk + ov[2]);
        e.clk = 6'(2 * lk + (md != 2'h3 ? 4 : 0) + (w ? 4 * xf : 0));
        e.mem = (md != 2'h3);
        e.rsel = rm;
        e.hi = ~w & rm[2];
        e.lk = lk;
        {e.cf, e.df, e.ief} = {cf_e, df_e, ie_e};
        {has_modrm, word_op, string_dest, mem_xfers} = {1'b1, w, sd, xf};
        exp_q.push_back(e);
        if (lk)
            send(`OAD_OP_LOCK);
        if (ov[2])
            send({3'b001, ov[1:0], 3'b110});
        send(8'h8b);
        send({md, 3'h2, rm});
        if (nd > 0)
            send(d[7:0]);
        if (nd > 1)
            send(d[15:8]);
        finish_instr();
    endtask
    ////////////////////////////////////////////////////////////////////////
    // monitor: oldest note against each result
    always @(negedge mclk)
    begin
        oad_exp_s e;
        if (decode_done === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk_bit("unexpected decode", 1'b0, 1'b1);
            else
            begin
                e = exp_q.pop_front();
                chk_bit("carry_flag", e.cf, carry_flag);
                chk_bit("direction_flag", e.df, direction_flag);
                chk_bit("irq_enable_flag", e.ief, irq_enable_flag);
                chk_bit("bus_lock", e.lk, bus_lock);
                chk_val("clocks", 16'(e.clk), 16'(clocks));
                chk_val("instr_len", 16'(e.len), 16'(instr_len));
                if (!e.fl)
                    chk_bit("reg_operand", ~e.mem, reg_operand);
                if (!e.fl && e.mem)
                    chk_val("ea", e.ea, effective_address);
                if (!e.fl && e.mem)
                    chk_val("seg", 16'(e.seg), 16'(seg_sel));
                if (!e.fl && !e.mem)
                    chk_val("reg_sel", 16'({e.hi, e.rsel}),
                        16'({reg_high_byte, reg_sel}));
            end
        end
    end
    // watchdog, well past the expected run length
    initial
    begin
        #200000;
        err_count++;
        complete_run();
    end
    initial
    begin
        logic [7:0] ops[7];
        ops = '{8'hf5, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
        {rst, has_modrm, word_op, string_dest, mem_xfers} = 6'h20;
        {bx_v, bp_v, si_v, di_v} = '0;
        {cf_e, df_e, ie_e} = 3'h0;
        rnd = 32'hd7fe0c10;
        err_count = 0;
        comparisons = 0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk_val("seg reset", 16'h0003, 16'(seg_sel));
        chk_bit("lock reset", 1'b0, bus_lock);
        for (int i = 0; i < 14; i++)
            flag_instr(i[0], ops[i % 7]);
        for (int i = 1; i >= 0; i--)
            plain_instr(i[0]);
        for (int m = 0; m < 4; m++)
            for (int r = 0; r < 8; r++)
            begin
                rnd_step();
                mem_instr(rnd[0], rnd[3:1], 2'(m), 3'(r), rnd[4],
                    (r == 5 && m != 3) & rnd[5],
                    m == 3 ? 2'h0 : rnd[7:6]);
            end
        repeat (20)
        begin
            rnd_step();
            mem_instr(rnd[0], {1'b1, rnd[2:1]}, 2'h0, 3'h5, rnd[4], 1'b1,
                rnd[7:6]);
        end
        complete_run();
    end
endmodule
